// ---- inc/tw_pkg.sv ----
package tw_pkg;

	// ---------------------------------------------------------------
	// slave addressing and pointer map
	// ---------------------------------------------------------------
	localparam logic [4:0] ADDR_HI       = 5'h13;
	localparam logic [4:0] HS_CODE_HI    = 5'h01;
	localparam logic [7:0] GC_ADDR       = 8'h00;
	localparam logic [7:0] GC_RESET      = 8'h06;
	localparam logic [7:0] PTR_RESET     = 8'h00;
	localparam logic [7:0] PTR_SOFT_RST  = 8'hFC;
	localparam logic [7:0] PTR_MAKER     = 8'hFE;
	localparam logic [7:0] PTR_PART      = 8'hFF;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_NS           = 4;
	localparam int TIMEOUT_MS       = 30;
	localparam int TIMEOUT_CYC      = TIMEOUT_MS * 1000000 / CLK_NS;
	localparam int PROBE_SETTLE_NS  = 2000;
	localparam int PROBE_SETTLE_CYC = (PROBE_SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SCL_PERIOD_NS    = 2500;
	localparam int SCL_QTR_CYC      = SCL_PERIOD_NS / (4 * CLK_NS);

	// ---------------------------------------------------------------
	// controller register port
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam int CMD_START    = 0;
	localparam int CMD_STOP     = 1;
	localparam int CMD_READ     = 2;
	localparam int CMD_NACK     = 3;
	localparam int CMD_DATA_LSB = 8;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_ACK     = 1;
	localparam int STAT_RX_LSB  = 8;

	// ---------------------------------------------------------------
	// state types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		DS_IDLE = 3'b000,
		DS_RX   = 3'b001,
		DS_ACK  = 3'b010,
		DS_TX   = 3'b011,
		DS_RACK = 3'b100,
		DS_IGN  = 3'b101
	} tw_dst_t;

	typedef enum logic [2:0] {
		BK_ADDR = 3'b000,
		BK_PTR  = 3'b001,
		BK_DATA = 3'b010,
		BK_GC   = 3'b011,
		BK_RD   = 3'b100
	} tw_kind_t;

	typedef enum logic [2:0] {
		PR_DONE = 3'b000,
		PR_A1   = 3'b100,
		PR_B1   = 3'b101,
		PR_A2   = 3'b110,
		PR_B2   = 3'b111
	} tw_probe_t;

	typedef enum logic [1:0] {
		MS_IDLE  = 2'b00,
		MS_START = 2'b01,
		MS_BIT   = 2'b10,
		MS_STOP  = 2'b11
	} tw_mst_t;

endpackage

// ---- inc/tw_if.sv ----
`timescale 1ns/10ps
interface tw_if;
	logic m_scl_oe_n;
	logic m_sda_oe_n;
	logic s_sda_oe_n;
	logic scl;
	logic sda;

	// ---------------------------------------------------------------
	// wired-and lines, pull-ups implied
	// ---------------------------------------------------------------
	assign scl = m_scl_oe_n;
	assign sda = m_sda_oe_n & s_sda_oe_n;

	modport dev(input scl, input sda, output s_sda_oe_n);
	modport host(input sda, output m_scl_oe_n, output m_sda_oe_n);
endinterface

// ---- rtl/tw_sync.sv ----
`timescale 1ns/10ps
module tw_sync #(
	parameter int W = 1
)(
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic         ce_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta_r <= '1;
			q_out  <= '1;
		end else if (ce_in) begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule // tw_sync

// ---- rtl/tw_slave.sv ----
// Behaviour
// - pointer FCh write resets everything
// - ack general call; 06h resets
// - other general-call codes do nothing
// - FEh/FFh return fixed read-only codes
// - START/STOP are SDA edges, SCL high
// - seven address bits plus direction, ack
// - eight bits plus ack; change SCL-low
// - slave only, fast and high-speed
// - every byte MSB first
// - four addresses from sensor polarities
// - probe pin one; low means bit zero
// - else probe pin two; repeat channel two
// - first written byte loads pointer
// - pointer kept for reads; pointer-only writes
// - two-byte registers send high byte first
// - master nacks last byte read
// - repeated START accepts new address
// - master sets byte count, no limit
// - ack held low through SCL high
// - master code: no ack, hs till STOP
// - 30ms low line resets interface
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
module tw_slave #(
	parameter logic [7:0] MAKER_CODE  = 8'hA5, // arbitrary value
	parameter logic [7:0] PART_CODE   = 8'h3C, // arbitrary value
	parameter int         TIMEOUT_CYC = tw_pkg::TIMEOUT_CYC,
	parameter int         SETTLE_CYC  = tw_pkg::PROBE_SETTLE_CYC
)(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	tw_if.dev                bus,
	output logic      [7:0]  ptr_out,
	output logic             wr_stb_out,
	output logic      [7:0]  wr_data_out,
	input  wire logic [15:0] rd_word_in,
	output logic             soft_rst_out,
	output logic             hs_mode_out,
	output logic             probe_force_out,
	output logic      [1:0]  probe_pin_out,
	input  wire logic        probe_high_in,
	output logic      [1:0]  anode_second_out
);
	localparam int TW = $clog2(TIMEOUT_CYC + 1);
	localparam int SW = $clog2(SETTLE_CYC + 1);

	logic [2:0]       sy;
	logic             scl_q_r;
	logic             sda_q_r;
	tw_pkg::tw_dst_t  st_r;
	tw_pkg::tw_kind_t kind_r;
	logic [3:0]       cnt_r;
	logic [7:0]       sh_r;
	logic [7:0]       tx_r;
	logic [7:0]       ptr_r;
	logic             ack_r;
	logic             ackm_r;
	logic             sda_oe_n_r;
	logic             hs_r;
	logic             wr_stb_r;
	logic [7:0]       wr_data_r;
	logic             srst_r;
	logic             srst_pend_r;
	logic [TW-1:0]    to_cnt_r;
	tw_pkg::tw_probe_t pr_st_r;
	logic [SW-1:0]    sc_r;
	logic [1:0]       addr_bits_r;

	// ---------------------------------------------------------------
	// line sampling and conditions
	// ---------------------------------------------------------------
	// 250 MHz oversampling leaves margin even at 3.4 MHz SCL
	tw_sync #(.W(3)) u_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.d_in     ({bus.scl, bus.sda, probe_high_in}),
		.q_out    (sy)
	);

	wire scl_s    = sy[2];
	wire sda_s    = sy[1];
	wire probe_s  = sy[0];
	wire scl_rise = scl_s & ~scl_q_r;
	wire scl_fall = ~scl_s & scl_q_r;
	wire sda_rise = sda_s & ~sda_q_r;
	wire start_c  = scl_s & scl_q_r & sda_q_r & ~sda_s;
	wire stop_c   = scl_s & scl_q_r & ~sda_q_r & sda_s;
	wire timeout  = (to_cnt_r == TW'(TIMEOUT_CYC));
	wire [7:0] rx_byte = {sh_r[6:0], sda_s};

	assign ptr_out          = ptr_r;
	assign wr_stb_out       = wr_stb_r;
	assign wr_data_out      = wr_data_r;
	assign soft_rst_out     = srst_r;
	assign hs_mode_out      = hs_r;
	assign probe_force_out  = pr_st_r[2];
	assign probe_pin_out    = pr_st_r[1:0];
	assign anode_second_out = addr_bits_r;
	assign bus.s_sda_oe_n   = sda_oe_n_r;

	function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic hi,
		input logic [15:0] w);
		if (p == tw_pkg::PTR_MAKER)
			rd_byte = MAKER_CODE;
		else if (p == tw_pkg::PTR_PART)
			rd_byte = PART_CODE;
		else
			rd_byte = hi ? w[15:8] : w[7:0];
	endfunction

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else if (ce_in) begin
			scl_q_r <= scl_s;
			sda_q_r <= sda_s;
		end
	end

	// ---------------------------------------------------------------
	// stuck-line timeout
	// ---------------------------------------------------------------
	// any rising line proves the bus is alive, so a stretch of TIMEOUT_CYC cycles outside idle with no rising scl or sda edge trips it
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			to_cnt_r <= '0;
		else if (ce_in) begin
			if (st_r == tw_pkg::DS_IDLE || scl_rise || sda_rise)
				to_cnt_r <= '0;
			else if (!timeout)
				to_cnt_r <= to_cnt_r + TW'(1);
		end
	end

	// ---------------------------------------------------------------
	// byte engine
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_r        <= tw_pkg::DS_IDLE;
			kind_r      <= tw_pkg::BK_ADDR;
			cnt_r       <= 4'h0;
			sh_r        <= 8'h00;
			tx_r        <= 8'h00;
			ptr_r       <= tw_pkg::PTR_RESET;
			ack_r       <= 1'b0;
			ackm_r      <= 1'b0;
			sda_oe_n_r  <= 1'b1;
			hs_r        <= 1'b0;
			wr_stb_r    <= 1'b0;
			wr_data_r   <= 8'h00;
			srst_r      <= 1'b0;
			srst_pend_r <= 1'b0;
		end else if (ce_in) begin
			wr_stb_r <= 1'b0;
			srst_r   <= 1'b0;
			if (timeout) begin
				st_r        <= tw_pkg::DS_IDLE;
				sda_oe_n_r  <= 1'b1;
				srst_pend_r <= 1'b0;
			end else if (start_c) begin
				st_r        <= tw_pkg::DS_RX;
				kind_r      <= tw_pkg::BK_ADDR;
				cnt_r       <= 4'h0;
				sda_oe_n_r  <= 1'b1;
				srst_pend_r <= 1'b0;
			end else if (stop_c) begin
				st_r        <= tw_pkg::DS_IDLE;
				sda_oe_n_r  <= 1'b1;
				hs_r        <= 1'b0;
				srst_pend_r <= 1'b0;
			end else begin
				unique case (st_r)
					tw_pkg::DS_IDLE, tw_pkg::DS_IGN: begin
					end
					tw_pkg::DS_RX: begin
						if (scl_rise) begin
							sh_r  <= rx_byte;
							cnt_r <= cnt_r + 4'h1;
							if (cnt_r == 4'h7) begin
								unique case (kind_r)
									tw_pkg::BK_ADDR: begin
										if (rx_byte[7:3] == tw_pkg::HS_CODE_HI) begin
											hs_r  <= 1'b1;
											ack_r <= 1'b0;
										end else if (rx_byte[7:1] == {tw_pkg::ADDR_HI, addr_bits_r}) begin
											ack_r  <= 1'b1;
											kind_r <= rx_byte[0] ? tw_pkg::BK_RD : tw_pkg::BK_PTR;
										end else if (rx_byte == tw_pkg::GC_ADDR) begin
											ack_r  <= 1'b1;
											kind_r <= tw_pkg::BK_GC;
										end else begin
											ack_r <= 1'b0;
										end
									end
									tw_pkg::BK_PTR: begin
										ptr_r  <= rx_byte;
										ack_r  <= 1'b1;
										kind_r <= tw_pkg::BK_DATA;
									end
									tw_pkg::BK_DATA: begin
										ack_r <= 1'b1;
										if (ptr_r == tw_pkg::PTR_SOFT_RST)
											srst_pend_r <= 1'b1;
										else if (ptr_r != tw_pkg::PTR_MAKER && ptr_r != tw_pkg::PTR_PART) begin
											wr_stb_r  <= 1'b1;
											wr_data_r <= rx_byte;
										end
									end
									tw_pkg::BK_GC: begin
										ack_r <= 1'b1;
										// other codes are acked and dropped
										if (rx_byte == tw_pkg::GC_RESET)
											srst_pend_r <= 1'b1;
									end
									tw_pkg::BK_RD: begin
										ack_r <= 1'b0;
									end
								endcase
							end
						end else if (scl_fall && cnt_r == 4'h8) begin
							cnt_r <= 4'h0;
							if (ack_r) begin
								st_r       <= tw_pkg::DS_ACK;
								sda_oe_n_r <= 1'b0;
							end else begin
								st_r <= tw_pkg::DS_IGN;
							end
						end
					end
					tw_pkg::DS_ACK: begin
						// released only at the fall that ends the ninth clock
						if (scl_fall) begin
							cnt_r <= 4'h0;
							if (srst_pend_r) begin
								srst_r      <= 1'b1;
								srst_pend_r <= 1'b0;
								ptr_r       <= tw_pkg::PTR_RESET;
								hs_r        <= 1'b0;
								sda_oe_n_r  <= 1'b1;
								st_r        <= tw_pkg::DS_IGN;
							end else if (kind_r == tw_pkg::BK_RD) begin
								tx_r       <= rd_byte(ptr_r, 1'b1, rd_word_in);
								sda_oe_n_r <= rd_byte(ptr_r, 1'b1, rd_word_in) >> 7 != 8'h00;
								st_r       <= tw_pkg::DS_TX;
							end else begin
								sda_oe_n_r <= 1'b1;
								st_r       <= tw_pkg::DS_RX;
							end
						end
					end
					tw_pkg::DS_TX: begin
						if (scl_rise)
							cnt_r <= cnt_r + 4'h1;
						else if (scl_fall) begin
							if (cnt_r == 4'h8) begin
								sda_oe_n_r <= 1'b1;
								st_r       <= tw_pkg::DS_RACK;
							end else begin
								tx_r       <= {tx_r[6:0], 1'b0};
								sda_oe_n_r <= tx_r[6];
							end
						end
					end
					tw_pkg::DS_RACK: begin
						if (scl_rise)
							ackm_r <= ~sda_s;
						else if (scl_fall) begin
							cnt_r <= 4'h0;
							if (ackm_r) begin
								tx_r       <= rd_byte(ptr_r, 1'b0, rd_word_in);
								sda_oe_n_r <= rd_byte(ptr_r, 1'b0, rd_word_in) >> 7 != 8'h00;
								st_r       <= tw_pkg::DS_TX;
							end else begin
								st_r <= tw_pkg::DS_IGN;
							end
						end
					end
					default: begin
						st_r       <= tw_pkg::DS_IDLE;
						sda_oe_n_r <= 1'b1;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// sensor polarity probe
	// ---------------------------------------------------------------
	// address answers with bits 00 after a reset; each bit takes its probed value as soon as its pin pair is read
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pr_st_r     <= tw_pkg::PR_A1;
			sc_r        <= '0;
			addr_bits_r <= 2'h0;
		end else if (ce_in) begin
			if (srst_r) begin
				pr_st_r     <= tw_pkg::PR_A1;
				sc_r        <= '0;
				addr_bits_r <= 2'h0;
			end else if (pr_st_r != tw_pkg::PR_DONE) begin
				if (sc_r != SW'(SETTLE_CYC - 1))
					sc_r <= sc_r + SW'(1);
				else begin
					sc_r <= '0;
					unique case (pr_st_r)
						tw_pkg::PR_A1: begin
							if (probe_s)
								pr_st_r <= tw_pkg::PR_B1;
							else begin
								addr_bits_r[1] <= 1'b0;
								pr_st_r        <= tw_pkg::PR_A2;
							end
						end
						tw_pkg::PR_B1: begin
							addr_bits_r[1] <= ~probe_s;
							pr_st_r        <= tw_pkg::PR_A2;
						end
						tw_pkg::PR_A2: begin
							if (probe_s)
								pr_st_r <= tw_pkg::PR_B2;
							else begin
								addr_bits_r[0] <= 1'b0;
								pr_st_r        <= tw_pkg::PR_DONE;
							end
						end
						tw_pkg::PR_B2: begin
							addr_bits_r[0] <= ~probe_s;
							pr_st_r        <= tw_pkg::PR_DONE;
						end
						default: pr_st_r <= tw_pkg::PR_DONE;
					endcase
				end
			end
		end
	end
endmodule // tw_slave

// ---- rtl/tw_master.sv ----
`timescale 1ns/10ps
module tw_master #(
	parameter int QTR_CYC = tw_pkg::SCL_QTR_CYC
)(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	tw_if.host               bus,
	input  wire logic [7:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [15:0] rdata_out
);
	localparam int DW = $clog2(QTR_CYC + 1);

	logic              sda_s;
	tw_pkg::tw_mst_t   st_r;
	logic [1:0]        q_r;
	logic [DW-1:0]     div_r;
	logic [3:0]        bit_r;
	logic              stop_r;
	logic              read_r;
	logic              nack_r;
	logic [7:0]        sh_r;
	logic [7:0]        rx_r;
	logic              ack_r;
	logic              scl_oe_n_r;
	logic              sda_oe_n_r;

	tw_sync #(.W(1)) u_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.d_in     (bus.sda),
		.q_out    (sda_s)
	);

	wire tick = (div_r == DW'(QTR_CYC - 1));
	wire busy = (st_r != tw_pkg::MS_IDLE);

	assign bus.m_scl_oe_n = scl_oe_n_r;
	assign bus.m_sda_oe_n = sda_oe_n_r;

	// ---------------------------------------------------------------
	// register port
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			rdata_out <= 16'h0000;
		else if (ce_in)
			rdata_out <= (rd_in && addr_in == tw_pkg::REG_STATUS) ?
				{rx_r, 6'h00, ack_r, busy} : 16'h0000;
	end

	// ---------------------------------------------------------------
	// bit sequencer, four quarters per SCL period
	// ---------------------------------------------------------------
	// commands written while busy are dropped; software polls the busy bit
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_r       <= tw_pkg::MS_IDLE;
			q_r        <= 2'h0;
			div_r      <= '0;
			bit_r      <= 4'h0;
			stop_r     <= 1'b0;
			read_r     <= 1'b0;
			nack_r     <= 1'b0;
			sh_r       <= 8'h00;
			rx_r       <= 8'h00;
			ack_r      <= 1'b0;
			scl_oe_n_r <= 1'b1;
			sda_oe_n_r <= 1'b1;
		end else if (ce_in) begin
			if (!busy) begin
				div_r <= '0;
				q_r   <= 2'h0;
				if (wr_in && addr_in == tw_pkg::REG_CMD) begin
					stop_r <= wdata_in[tw_pkg::CMD_STOP];
					read_r <= wdata_in[tw_pkg::CMD_READ];
					nack_r <= wdata_in[tw_pkg::CMD_NACK];
					sh_r   <= wdata_in[tw_pkg::CMD_DATA_LSB +: 8];
					bit_r  <= 4'h0;
					st_r   <= wdata_in[tw_pkg::CMD_START] ? tw_pkg::MS_START : tw_pkg::MS_BIT;
				end
			end else if (!tick)
				div_r <= div_r + DW'(1);
			else begin
				div_r <= '0;
				q_r   <= q_r + 2'h1;
				unique case (st_r)
					tw_pkg::MS_START: begin
						unique case (q_r)
							2'h0: sda_oe_n_r <= 1'b1;
							2'h1: scl_oe_n_r <= 1'b1;
							2'h2: sda_oe_n_r <= 1'b0;
							2'h3: begin
								scl_oe_n_r <= 1'b0;
								st_r       <= tw_pkg::MS_BIT;
							end
						endcase
					end
					tw_pkg::MS_BIT: begin
						unique case (q_r)
							2'h0: begin
								// data moves only with SCL low
								if (bit_r == 4'h8)
									sda_oe_n_r <= read_r ? nack_r : 1'b1;
								else
									sda_oe_n_r <= read_r ? 1'b1 : sh_r[7];
							end
							2'h1: scl_oe_n_r <= 1'b1;
							2'h2: begin
								if (bit_r == 4'h8)
									ack_r <= ~sda_s;
								else
									sh_r <= {sh_r[6:0], sda_s};
							end
							2'h3: begin
								// ack stays driven until after this fall
								scl_oe_n_r <= 1'b0;
								if (bit_r == 4'h8) begin
									rx_r <= sh_r;
									st_r <= stop_r ? tw_pkg::MS_STOP : tw_pkg::MS_IDLE;
								end else
									bit_r <= bit_r + 4'h1;
							end
						endcase
					end
					tw_pkg::MS_STOP: begin
						unique case (q_r)
							2'h0: sda_oe_n_r <= 1'b0;
							2'h1: scl_oe_n_r <= 1'b1;
							2'h2: sda_oe_n_r <= 1'b1;
							2'h3: st_r <= tw_pkg::MS_IDLE;
						endcase
					end
					default: st_r <= tw_pkg::MS_IDLE;
				endcase
			end
		end
	end
endmodule // tw_master

// ---- testbench/tw_link_sva.sv ----
`timescale 1ns/10ps
module tw_link_sva #(
	parameter int TIMEOUT_CYC = 2000
)(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic m_scl_oe_n,
	input  wire logic m_sda_oe_n,
	input  wire logic s_sda_oe_n,
	input  wire logic scl,
	input  wire logic sda
);
	// ---------------------------------------------------------------
	// helper: cycles the target has held sda low since the last scl rise
	// ---------------------------------------------------------------
	logic [15:0] low_cnt_r;
	logic        scl_q_r;

	// a rising scl restarts the target's own stuck-line count, so restart here too
	always_ff @(posedge clk_in) begin
		scl_q_r <= scl;
		if (!rst_n_in || s_sda_oe_n || (scl && !scl_q_r))
			low_cnt_r <= 16'h0000;
		else
			low_cnt_r <= low_cnt_r + 16'h0001;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence start_s;
		$fell(sda) && scl && $past(scl);
	endsequence
	sequence stop_s;
		$rose(sda) && scl && $past(scl);
	endsequence

	// ---------------------------------------------------------------
	// wire rules
	// ---------------------------------------------------------------
	a_sda_hold_high: assert property (scl && $past(scl) |-> $stable(s_sda_oe_n))
		else $error("target moved sda while scl high");
	a_ack_low_held: assert property ($rose(scl) && !s_sda_oe_n |-> !s_sda_oe_n [*8])
		else $error("target low level not held through scl high");
	a_scl_high_len: assert property ($rose(m_scl_oe_n) |-> scl [*8])
		else $error("scl high phase too short");
	a_scl_low_len: assert property ($fell(scl) |-> !scl [*8])
		else $error("scl low phase too short");
	a_drive_edge: assert property ($changed(s_sda_oe_n) |-> !scl && !$past(scl, 2))
		else $error("target changed sda outside scl low");
	a_start_quiet: assert property (start_s |-> s_sda_oe_n [*8])
		else $error("target drives sda right after start");
	a_stop_quiet: assert property (stop_s |=> s_sda_oe_n [*8])
		else $error("target drives sda after stop");
	a_timeout_bound: assert property (int'(low_cnt_r) <= TIMEOUT_CYC + 8)
		else $error("target held sda low past timeout");
	a_master_yields: assert property (!s_sda_oe_n && scl |-> m_sda_oe_n)
		else $error("both ends drive sda in one bit");

	c_start: cover property (start_s);
	c_ack: cover property ($rose(scl) && !s_sda_oe_n);
	c_timeout: cover property (low_cnt_r > 16'h03E8);
endmodule // tw_link_sva

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	localparam int         TO_CYC = 2000;
	localparam logic [3:0] F_S    = 4'h1;
	localparam logic [3:0] F_P    = 4'h2;
	localparam logic [3:0] F_R    = 4'h4;
	localparam logic [3:0] F_N    = 4'h8;

	logic        clk_in   = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [7:0]  addr_r   = 8'h00;
	logic [15:0] wdata_r  = 16'h0000;
	logic        wr_r     = 1'b0;
	logic        rd_r     = 1'b0;
	logic        ce_r     = 1'b1;
	logic [15:0] word_r   = 16'h0000;
	logic [3:0]  pins_r   = 4'h0;
	logic [15:0] rdata, st;
	logic [7:0]  ptr, wr_data;
	logic [1:0]  ppin, anode;
	logic        wr_stb, srst, hs, pforce, phigh;
	logic [6:0]  dev;
	int          err_count = 0;
	int          n_checks  = 0;
	int          n_rst     = 0;
	int          n_wr      = 0;
	int          cyc       = 0;

	tw_if bus_if();
	tw_master #(.QTR_CYC(8)) i_tw_master (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_r),
		.bus(bus_if), .addr_in(addr_r), .wdata_in(wdata_r), .wr_in(wr_r), .rd_in(rd_r),
		.rdata_out(rdata));
	tw_slave #(.MAKER_CODE(8'h6B), .PART_CODE(8'h4D), .TIMEOUT_CYC(TO_CYC), .SETTLE_CYC(8))
	i_tw_slave (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_r), .bus(bus_if),
		.ptr_out(ptr), .wr_stb_out(wr_stb), .wr_data_out(wr_data), .rd_word_in(word_r),
		.soft_rst_out(srst), .hs_mode_out(hs), .probe_force_out(pforce), .probe_pin_out(ppin),
		.probe_high_in(phigh), .anode_second_out(anode));
	tw_link_sva #(.TIMEOUT_CYC(TO_CYC)) i_tw_link_sva (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.m_scl_oe_n(bus_if.m_scl_oe_n), .m_sda_oe_n(bus_if.m_sda_oe_n),
		.s_sda_oe_n(bus_if.s_sda_oe_n), .scl(bus_if.scl), .sda(bus_if.sda));

	// ---------------------------------------------------------------
	// sense pins: a set bit is a pin that pulls up when forced
	// ---------------------------------------------------------------
	assign phigh = pforce & pins_r[ppin];

	always #2 clk_in = ~clk_in;

	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (srst === 1'b1)
			n_rst <= n_rst + 1;
		if (wr_stb === 1'b1)
			n_wr <= n_wr + 1;
		if (cyc == 60000) begin
			err_count++;
			results();
		end
	end

	function automatic logic [1:0] abits(input logic [3:0] p);
		return {p[0] & ~p[1], p[2] & ~p[3]};
	endfunction

	task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk_bit(input string nm, input logic exp, input logic got);
		chk_byte(nm, {7'h00, exp}, {7'h00, got});
	endtask
	task automatic chk_cnt(input string nm, input int exp, input int got);
		n_checks++;
		if (got != exp) begin
			err_count++;
			$display("[ERR] %s expected %0d seen %0d", nm, exp, got);
		end
	endtask

	// ---------------------------------------------------------------
	// register port and controller commands
	// ---------------------------------------------------------------
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_r <= a;
		wdata_r <= d;
		wr_r <= 1'b1;
		@(posedge clk_in);
		wr_r <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_in);
		addr_r <= a;
		rd_r <= 1'b1;
		@(posedge clk_in);
		rd_r <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic mcmd(input logic [3:0] f, input logic [7:0] b);
		int n;
		n = 0;
		reg_wr(tw_pkg::REG_CMD, {b, 4'h0, f});
		do begin
			reg_rd(tw_pkg::REG_STATUS, st);
			n++;
		end while (st[tw_pkg::STAT_BUSY] !== 1'b0 && n < 300);
		chk_bit("controller idle", 1'b0, st[tw_pkg::STAT_BUSY]);
	endtask
	task automatic set_ptr(input logic [7:0] p);
		mcmd(F_S, {dev, 1'b0});
		chk_bit("address ack", 1'b1, st[tw_pkg::STAT_ACK]);
		mcmd(F_P, p);
	endtask
	task automatic read1(output logic [7:0] b);
		mcmd(F_S, {dev, 1'b1});
		mcmd(F_R | F_N | F_P, 8'h00);
		b = st[15:8];
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_probe();
		logic [15:0] cfgs;
		logic [7:0]  b;
		int          k;
		cfgs = {4'b1101, 4'b0111, 4'b0101, 4'b0000};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in);
			pins_r <= cfgs[i*4 +: 4];
			k = n_rst;
			mcmd(F_S, tw_pkg::GC_ADDR);
			chk_bit("call ack", 1'b1, st[tw_pkg::STAT_ACK]);
			mcmd(F_P, tw_pkg::GC_RESET);
			chk_bit("call code ack", 1'b1, st[tw_pkg::STAT_ACK]);
			chk_cnt("call reset pulses", k + 1, n_rst);
			repeat (40) @(posedge clk_in);
			chk_byte("address bits", {6'h00, abits(pins_r)}, {6'h00, anode});
			dev = {tw_pkg::ADDR_HI, abits(pins_r)};
			set_ptr(tw_pkg::PTR_MAKER);
			read1(b);
			chk_byte("maker code", 8'h6B, b);
		end
	endtask

	task automatic t_write();
		logic [7:0] b;
		int         k;
		set_ptr(8'h12);
		chk_byte("pointer only", 8'h12, ptr);
		k = n_rst;
		mcmd(F_S, tw_pkg::GC_ADDR);
		mcmd(F_P, 8'h05);
		chk_bit("call other ack", 1'b1, st[tw_pkg::STAT_ACK]);
		chk_cnt("no reset", k, n_rst);
		chk_byte("pointer kept", 8'h12, ptr);
		k = n_wr;
		mcmd(F_S, {dev, 1'b0});
		mcmd(4'h0, 8'h21);
		mcmd(4'h0, 8'h5B);
		mcmd(4'h0, 8'hC6);
		chk_cnt("write strobes", k + 2, n_wr);
		chk_byte("write data", 8'hC6, wr_data);
		chk_byte("pointer", 8'h21, ptr);
		word_r <= 16'hB469;
		mcmd(F_S, {dev, 1'b1});
		chk_bit("restart ack", 1'b1, st[tw_pkg::STAT_ACK]);
		mcmd(F_R, 8'h00);
		chk_byte("high byte", 8'hB4, st[15:8]);
		mcmd(F_R | F_N | F_P, 8'h00);
		chk_byte("low byte", 8'h69, st[15:8]);
		read1(b);
		chk_byte("reread", 8'hB4, b);
	endtask

	task automatic t_ident();
		logic [7:0] b;
		int         k;
		k = n_wr;
		mcmd(F_S, {dev, 1'b0});
		// both ends frozen before the byte's first bit: without the freeze the byte would be done
		reg_wr(tw_pkg::REG_CMD, {tw_pkg::PTR_MAKER, 8'h00});
		ce_r <= 1'b0;
		repeat (400) @(posedge clk_in);
		ce_r <= 1'b1;
		reg_rd(tw_pkg::REG_STATUS, st);
		chk_bit("frozen byte busy", 1'b1, st[tw_pkg::STAT_BUSY]);
		repeat (400) @(posedge clk_in);
		mcmd(F_P, 8'h11);
		chk_bit("code write ack", 1'b1, st[tw_pkg::STAT_ACK]);
		chk_cnt("code write strobes", k, n_wr);
		read1(b);
		chk_byte("maker unchanged", 8'h6B, b);
		set_ptr(tw_pkg::PTR_PART);
		read1(b);
		chk_byte("part code", 8'h4D, b);
	endtask

	task automatic t_soft();
		int k;
		k = n_rst;
		mcmd(F_S, {dev, 1'b0});
		mcmd(4'h0, tw_pkg::PTR_SOFT_RST);
		mcmd(F_P, 8'h3E);
		chk_bit("reset byte ack", 1'b1, st[tw_pkg::STAT_ACK]);
		chk_cnt("soft reset pulses", k + 1, n_rst);
		chk_byte("pointer cleared", tw_pkg::PTR_RESET, ptr);
		repeat (40) @(posedge clk_in);
		chk_byte("address reprobed", {6'h00, abits(pins_r)}, {6'h00, anode});
	endtask

	task automatic t_addr_hs();
		mcmd(F_S, {dev ^ 7'h03, 1'b0});
		chk_bit("foreign ack", 1'b0, st[tw_pkg::STAT_ACK]);
		mcmd(F_P, 8'h00);
		mcmd(F_S, 8'h0D);
		chk_bit("master code ack", 1'b0, st[tw_pkg::STAT_ACK]);
		chk_bit("fast filters off", 1'b1, hs);
		set_ptr(8'h44);
		chk_bit("back to fast", 1'b0, hs);
		chk_byte("pointer after code", 8'h44, ptr);
	endtask

	task automatic t_timeout();
		logic [7:0] b;
		word_r <= 16'h2A00;
		set_ptr(8'h30);
		mcmd(F_S, {dev, 1'b1});
		repeat (4) @(posedge clk_in);
		chk_bit("first bit on wire", 1'b0, bus_if.sda);
		repeat (TO_CYC + 100) @(posedge clk_in);
		chk_bit("stuck line freed", 1'b1, bus_if.s_sda_oe_n);
		read1(b);
		chk_byte("read after timeout", 8'h2A, b);
		mcmd(F_S, {dev, 1'b1});
		mcmd(F_R | F_N, 8'h00);
		repeat (8) @(posedge clk_in);
		chk_bit("freed after nack", 1'b1, bus_if.s_sda_oe_n);
		set_ptr(8'h30);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (40) @(posedge clk_in);
		dev = {tw_pkg::ADDR_HI, 2'b00};
		t_probe();
		$display("probe test done, mismatches %0d", err_count);
		t_write();
		$display("write test done, mismatches %0d", err_count);
		t_ident();
		$display("ident test done, mismatches %0d", err_count);
		t_soft();
		$display("soft reset test done, mismatches %0d", err_count);
		t_addr_hs();
		$display("address test done, mismatches %0d", err_count);
		t_timeout();
		$display("timeout test done, mismatches %0d", err_count);
		results();
	end
endmodule // testbench
